// ===== pkg/tmc_pkg.sv
package tmc_pkg;

   // register offsets on the local serial control bus
   localparam logic [7:0] ADDR_FUNC_MODE = 8'h0A;
   localparam logic [7:0] ADDR_OUT_CTRL  = 8'h0C;

   // function_mode_control fields
   localparam int FM_MODE_LSB = 0;
   localparam int FM_STAT_BIT = 2;
   localparam int FM_BLANK_BIT = 3;
   localparam int FM_ARC_DIS_BIT = 4;
   localparam logic [7:0] FM_RESET = 8'h82;

   // output_swing_deemphasis_control fields
   localparam int OC_DE_LSB = 0;
   localparam int OC_SW_LSB = 5;
   localparam logic [7:0] OC_RESET = 8'h00;

   // function_mode_field codes, 2'h3 behaves as automatic
   localparam logic [1:0] FM_REDRIVER = 2'h0;
   localparam logic [1:0] FM_RETIMER  = 2'h1;
   localparam logic [1:0] FM_AUTO     = 2'h2;

   localparam logic [1:0] DE_0DB   = 2'h0;
   localparam logic [1:0] DE_2DB   = 2'h1;
   localparam logic [2:0] SW_BOOST = 3'h3;
   localparam logic [2:0] SW_PIN   = 3'h0;

   // timing base and pixel clock measurement
   localparam int CLK_MHZ = 20;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PIX_PRESCALE = 64;
   localparam int WIN_W = 12;
   localparam int REF_WIN_CYC = 4096;
   localparam int CNT_W = 12;
   localparam int PIX_ON_MHZ = 100;
   localparam int PIX_OFF_MHZ = 90;
   localparam int PIX_MAX_MHZ = 340;
   localparam int PIX_TERM_MHZ = 200;
   localparam int RES_DELTA = 8;
   localparam int CNT_ON = PIX_ON_MHZ * REF_WIN_CYC / (CLK_MHZ * PIX_PRESCALE);
   localparam int CNT_OFF = PIX_OFF_MHZ * REF_WIN_CYC / (CLK_MHZ * PIX_PRESCALE);
   localparam int CNT_MAX = PIX_MAX_MHZ * REF_WIN_CYC / (CLK_MHZ * PIX_PRESCALE);
   localparam int CNT_TERM = PIX_TERM_MHZ * REF_WIN_CYC / (CLK_MHZ * PIX_PRESCALE);

   // acquisition and clock_data_recovery timing
   localparam int ACQ_W = 19;
   localparam int ACQ_TIME_MS = 7;
   localparam int ACQ_CYC = ACQ_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CDR_ON_MAX_MS = 15;
   localparam int CDR_ON_MAX_CYC = CDR_ON_MAX_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CDR_OFF_MAX_NS = 120;
   localparam int CDR_OFF_MAX_CYC = CDR_OFF_MAX_NS / CLK_PERIOD_NS;

   typedef enum {ST_REDRIVE, ST_FREQ, ST_LOCK, ST_RUN} tmc_state_type;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmc_reg_req_type;

   typedef struct packed {
      logic       cdr_pll_en;
      logic       retime_en;
      logic       drv_en;
      logic       io_hiz;
      logic       tx_term_en;
      logic [1:0] deemph;
      logic [2:0] swing;
      logic       pre_emph;
   } tmc_drv_type;

endpackage

// ===== hw/tmc_mode_ctrl.sv
`timescale 1ns/1ps
// Function
// [R1] audio return on by default, register disables
// [R2] no transmit termination below 2 Gbps
// [R3] termination pin: high off, float automatic
// [R4] pin strap: de-emphasis pin picks -2/0 dB
// [R5] register mode: de-emphasis from bits 1:0
// [R6] swing 011 with de-emphasis 01 pre-emphasizes
// [R7] de-emphasis only in retimer mode
// [R8] automatic: retimer above about 100 MHz
// [R9] automatic retimer range 100 to 340 MHz
// [R10] resolution change restarts 7 ms acquisition
// [R11] optional driver blanking until lock
// [R12] function mode field can force retimer
// [R13] field 00 forces redriver everywhere
// [R14] redriver powers down recovery and PLL
// [R15] automatic: redriver below 1.0 Gbps; once retiming, the code returns to redriver below 90 MHz or above 340 MHz
// [R16] redriver drops skew compensation, retiming
// [R17] host forces PLL lock for jitter tests
// [R18] output enable low: controls ignored, high-z
// [R19] recovery active within 15 ms
// [R20] recovery off within 120 ns
// [R21] rate counted per window with hysteresis
module tmc_mode_ctrl
   import tmc_pkg::*;
#(
   parameter int ACQ_CYCLES   = ACQ_CYC,
   parameter int CDR_ON_LIMIT = CDR_ON_MAX_CYC
) (
   input  wire logic            clk_sys,
   input  wire logic            rst_n,
   input  wire logic            oe_pin,
   input  wire logic            pix_clk_in,
   input  wire logic            term_sel_high,
   input  wire logic            term_sel_float,
   input  wire logic            deemph_pin_low,
   input  wire logic            i2c_mode,
   input  wire tmc_reg_req_type reg_req,
   output logic [7:0]           reg_rdata,
   output tmc_drv_type          drv,
   output logic                 audio_return_output,
   output logic                 rate_valid,
   input  wire logic            rate_ready,
   output logic [CNT_W-1:0]     rate_data
);

   logic [5:0]          sync1_r;
   logic [5:0]          sync2_r;
   logic                pix_d_r;
   logic                oe_s;
   logic                term_hi_s;
   logic                term_fl_s;
   logic                de_low_s;
   logic                i2c_s;
   logic                pix_rise;
   logic                ctl_rst;
   logic [7:0]          fm_r;
   logic [7:0]          oc_r;
   logic [WIN_W-1:0]    win_cnt_r;
   logic [CNT_W-1:0]    edge_cnt_r;
   logic [CNT_W-1:0]    meas_r;
   logic [CNT_W-1:0]    diff;
   logic                win_last;
   logic                win_done;
   logic                rate_hi_r;
   logic                rate_term_r;
   logic                res_chg_r;
   logic                want_rt;
   logic [ACQ_W-1:0]    acq_cnt_r;
   tmc_state_type       state_r;
   tmc_state_type       state_nxt;
   logic [CNT_W-1:0]    fifo_mem [2];
   logic                wp_r;
   logic                rp_r;
   logic [1:0]          fcnt_r;
   logic                fifo_in_rdy;
   logic                pop;

   function automatic logic hit(tmc_reg_req_type r, logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   // two-stage synchronisers; only the second stage is read
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         pix_d_r <= 1'b0;
      end else begin
         sync1_r <= {i2c_mode, deemph_pin_low, term_sel_float,
                     term_sel_high, pix_clk_in, oe_pin};
         sync2_r <= sync1_r;
         pix_d_r <= sync2_r[1];
      end
   end

   assign oe_s      = sync2_r[0];
   assign term_hi_s = sync2_r[2];
   assign term_fl_s = sync2_r[3];
   assign de_low_s  = sync2_r[4];
   assign i2c_s     = sync2_r[5];
   assign pix_rise  = sync2_r[1] & ~pix_d_r;
   // output enable low returns all control state to reset
   assign ctl_rst   = !rst_n || !oe_s; // see [R18]

   // registers; contents are lost whenever output enable drops
   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         fm_r <= FM_RESET;
         oc_r <= OC_RESET;
      end else begin
         if (hit(reg_req, ADDR_FUNC_MODE)) begin
            fm_r <= reg_req.wdata; // see [R1] [R12]
         end
         if (hit(reg_req, ADDR_OUT_CTRL)) begin
            oc_r <= reg_req.wdata; // see [R5] [R6]
         end
      end
   end

   // read data one cycle after the address; status bit is live
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.addr == ADDR_FUNC_MODE) begin
         reg_rdata <= fm_r;
         reg_rdata[FM_STAT_BIT] <= (state_r == ST_RUN);
      end else if (reg_req.addr == ADDR_OUT_CTRL) begin
         reg_rdata <= oc_r;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // reference window; held at its last count while the buffer is full, so a stalled
   // reader delays the measurement instead of losing a word
   assign win_last = (win_cnt_r == WIN_W'(REF_WIN_CYC - 1));
   assign win_done = win_last && fifo_in_rdy;

   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         win_cnt_r  <= '0;
         edge_cnt_r <= '0;
      end else if (win_done) begin
         win_cnt_r  <= '0;
         edge_cnt_r <= CNT_W'(pix_rise); // see [R21]
      end else if (!win_last) begin
         win_cnt_r  <= win_cnt_r + 1'b1;
         edge_cnt_r <= edge_cnt_r + CNT_W'(pix_rise); // see [R21]
      end
   end

   assign diff = (edge_cnt_r > meas_r) ? edge_cnt_r - meas_r
                                       : meas_r - edge_cnt_r;

   // rate class with a gap between on and off thresholds
   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         meas_r      <= '0;
         rate_hi_r   <= 1'b0;
         rate_term_r <= 1'b0;
         res_chg_r   <= 1'b0;
      end else begin
         res_chg_r <= 1'b0;
         if (win_done) begin
            meas_r <= edge_cnt_r;
            if (edge_cnt_r >= CNT_W'(CNT_ON) &&
                edge_cnt_r <= CNT_W'(CNT_MAX)) begin
               rate_hi_r <= 1'b1; // see [R8] [R9]
            end else if (edge_cnt_r < CNT_W'(CNT_OFF) ||
                         edge_cnt_r > CNT_W'(CNT_MAX)) begin
               rate_hi_r <= 1'b0; // see [R15] [R21]
            end
            rate_term_r <= edge_cnt_r >= CNT_W'(CNT_TERM); // see [R2]
            res_chg_r   <= diff > CNT_W'(RES_DELTA); // see [R10]
         end
      end
   end

   // mode choice; forced retimer also serves forced-lock testing
   always_comb begin
      case (fm_r[FM_MODE_LSB +: 2])
         FM_REDRIVER: want_rt = 1'b0; // see [R13]
         FM_RETIMER:  want_rt = 1'b1; // see [R12] [R17]
         default:     want_rt = rate_hi_r; // see [R8]
      endcase
   end

   // acquisition: one frequency window, then lock; both count toward the acquisition time
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_REDRIVE: begin
            if (want_rt) begin
               state_nxt = ST_FREQ;
            end
         end
         ST_FREQ: begin
            if (win_done) begin
               state_nxt = ST_LOCK;
            end
         end
         ST_LOCK: begin
            if (acq_cnt_r >= ACQ_W'(ACQ_CYCLES - 1)) begin
               state_nxt = ST_RUN; // see [R10]
            end
         end
         ST_RUN: begin
            if (res_chg_r) begin
               state_nxt = ST_FREQ; // see [R10]
            end
         end
         default: state_nxt = ST_REDRIVE;
      endcase
      if (!want_rt) begin
         state_nxt = ST_REDRIVE; // see [R14]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         state_r   <= ST_REDRIVE;
         acq_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_FREQ || state_r == ST_LOCK) begin
            acq_cnt_r <= acq_cnt_r + 1'b1;
         end else begin
            acq_cnt_r <= '0;
         end
      end
   end

   // driver controls, registered; two edges from mode drop to off
   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         drv        <= '0;
         drv.io_hiz <= 1'b1; // see [R18]
      end else begin
         drv.cdr_pll_en <= (state_r != ST_REDRIVE); // see [R14] [R20]
         drv.retime_en  <= (state_r == ST_RUN); // see [R16]
         drv.drv_en     <= !(fm_r[FM_BLANK_BIT] && // see [R11]
                             (state_r == ST_FREQ || state_r == ST_LOCK));
         drv.io_hiz     <= 1'b0;
         // low pin level is reserved and treated as off
         drv.tx_term_en <= term_fl_s && !term_hi_s && rate_term_r; // see [R3]
         if (state_r != ST_RUN) begin
            drv.deemph <= DE_0DB; // see [R7]
         end else if (i2c_s) begin
            drv.deemph <= oc_r[OC_DE_LSB +: 2]; // see [R5]
         end else begin
            drv.deemph <= de_low_s ? DE_2DB : DE_0DB; // see [R4]
         end
         drv.swing    <= i2c_s ? oc_r[OC_SW_LSB +: 3] : SW_PIN;
         drv.pre_emph <= i2c_s && state_r == ST_RUN && // see [R6]
                         oc_r[OC_SW_LSB +: 3] == SW_BOOST &&
                         oc_r[OC_DE_LSB +: 2] == DE_2DB;
      end
   end

   // audio return path follows the disable bit
   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         audio_return_output <= 1'b0;
      end else begin
         audio_return_output <= !fm_r[FM_ARC_DIS_BIT]; // see [R1]
      end
   end

   // two-entry buffer of window counts for the rate reader
   assign fifo_in_rdy = (fcnt_r != 2'h2);
   assign rate_valid  = (fcnt_r != 2'h0);
   assign pop         = rate_valid && rate_ready;
   assign rate_data   = fifo_mem[rp_r];

   always_ff @(posedge clk_sys) begin
      if (ctl_rst) begin
         wp_r   <= 1'b0;
         rp_r   <= 1'b0;
         fcnt_r <= 2'h0;
         fifo_mem[0] <= '0;
         fifo_mem[1] <= '0;
      end else begin
         if (win_done) begin
            fifo_mem[wp_r] <= edge_cnt_r;
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         fcnt_r <= 2'(fcnt_r + {1'b0, win_done} - {1'b0, pop});
      end
   end

   // helper: cycles spent wanting the retimer without retiming enabled
   logic [19:0] on_wait_r;
   always_ff @(posedge clk_sys) begin
      if (ctl_rst || !want_rt || drv.retime_en) begin
         on_wait_r <= '0;
      end else begin
         on_wait_r <= on_wait_r + 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_arc_disable_write: assert property ( // see [R1]
      (oe_s && hit(reg_req, ADDR_FUNC_MODE) &&
       reg_req.wdata[FM_ARC_DIS_BIT]) |-> ##2 !audio_return_output)
      else $error("audio return not disabled by write");
   a_term_rate_low: assert property ( // see [R2]
      !rate_term_r |=> !drv.tx_term_en)
      else $error("termination on below threshold");
   a_term_pin_high: assert property ( // see [R3]
      term_hi_s |=> !drv.tx_term_en)
      else $error("termination on with pin high");
   a_deemph_pin_sel: assert property ( // see [R4]
      (oe_s && state_r == ST_RUN && !i2c_s && de_low_s)
      |=> drv.deemph == DE_2DB)
      else $error("pin de-emphasis not applied");
   a_deemph_reg_sel: assert property ( // see [R5]
      (oe_s && state_r == ST_RUN && i2c_s)
      |=> drv.deemph == $past(oc_r[OC_DE_LSB +: 2]))
      else $error("register de-emphasis not applied");
   a_pre_emph_combo: assert property ( // see [R6]
      (oe_s && state_r == ST_RUN && i2c_s && oc_r == 8'h61)
      |=> drv.pre_emph)
      else $error("pre-emphasis combination missed");
   a_deemph_redrive: assert property ( // see [R7]
      (state_r != ST_RUN) |=> drv.deemph == DE_0DB)
      else $error("de-emphasis outside retimer mode");
   a_auto_low_rate: assert property ( // see [R15]
      (fm_r[1:0] == FM_AUTO && win_done &&
       edge_cnt_r < CNT_W'(CNT_OFF)) |=> ##[1:2] state_r == ST_REDRIVE)
      else $error("retimer kept below low threshold");
   a_blank_until_lock: assert property ( // see [R11]
      (oe_s && fm_r[FM_BLANK_BIT] && state_r == ST_FREQ) |=> !drv.drv_en)
      else $error("drivers live while blanking");
   a_forced_redrive: assert property ( // see [R13]
      (oe_s && fm_r[1:0] == FM_REDRIVER) |=> ##1 !drv.cdr_pll_en)
      else $error("recovery on in forced redriver");
   a_cdr_off_fast: assert property ( // see [R20]
      $fell(want_rt) |-> ##[1:2] !drv.cdr_pll_en)
      else $error("recovery not off in time");
   a_cdr_on_bound: assert property ( // see [R19]
      on_wait_r < 20'(CDR_ON_LIMIT))
      else $error("recovery not active in time");
   a_hiz_on_oe_low: assert property ( // see [R18]
      !oe_s |=> drv.io_hiz && !drv.cdr_pll_en)
      else $error("outputs not high-z with enable low");

   c_lock_reached: cover property (state_r == ST_LOCK ##1 state_r == ST_RUN);
   c_res_restart: cover property (state_r == ST_RUN && res_chg_r);
   c_buffer_full: cover property (fcnt_r == 2'h2 && !rate_ready);

endmodule

// ===== test/tmc_pix_src.sv
`timescale 1ns/1ps
// upstream source model: prescaled pixel clock, free running like video
module tmc_pix_src (
   input  wire logic [15:0] half_ns,
   output logic             pix_clk
);
   // a new half period acts as a resolution change upstream
   initial begin
      pix_clk = 1'b0;
      forever begin
         #(half_ns) pix_clk = ~pix_clk;
      end
   end
endmodule

// ===== test/tb_tmc_mode_ctrl.sv
`timescale 1ns/1ps
module tb_tmc_mode_ctrl
   import tmc_pkg::*;
;
   // one measurement window plus margin for the push
   localparam int WIN = REF_WIN_CYC + 200;

   logic             clk_sys, rst_n, oe_pin, pix_clk_in;
   logic             term_sel_high, term_sel_float, deemph_pin_low;
   logic             i2c_mode, audio_return_output, rate_valid, rate_ready;
   logic [7:0]       reg_rdata;
   logic [CNT_W-1:0] rate_data;
   logic [15:0]      pix_half;
   tmc_reg_req_type  reg_req;
   tmc_drv_type      drv;
   int               n_fail, num_checks;
   int               cyc = 0;

   // small acquisition count keeps the run short
   tmc_mode_ctrl #(.ACQ_CYCLES(100), .CDR_ON_LIMIT(20000)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .oe_pin(oe_pin),
      .pix_clk_in(pix_clk_in), .term_sel_high(term_sel_high),
      .term_sel_float(term_sel_float), .deemph_pin_low(deemph_pin_low),
      .i2c_mode(i2c_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .drv(drv), .audio_return_output(audio_return_output),
      .rate_valid(rate_valid), .rate_ready(rate_ready),
      .rate_data(rate_data));

   tmc_pix_src u_src (.half_ns(pix_half), .pix_clk(pix_clk_in));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // hang guard, about 70 percent above the length of the whole test run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc >= 100000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // window counts may differ by one edge with the phase of the source
   task automatic chk_rng(input logic [11:0] got, input logic [11:0] lo,
                          input logic [11:0] hi);
      num_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_req = '{1'b1, a, d};
      @(negedge clk_sys);
      reg_req.wr = 1'b0;
   endtask

   // read data is registered, so look one edge after the address
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_req = '{1'b0, a, 8'h00};
      @(negedge clk_sys);
      chk({4'h0, reg_rdata}, {4'h0, exp});
   endtask

   // bounded wait on one drive level: 0 retime, 1 drivers, 2 termination,
   // 3 recovery; recovery off means redriver, not a mere restart
   task automatic wait_sig(input int sel, input logic e);
      logic s;
      for (int i = 0; i < 3 * WIN; i++) begin
         @(negedge clk_sys);
         case (sel)
            0: s = drv.retime_en;
            1: s = drv.drv_en;
            2: s = drv.tx_term_en;
            default: s = drv.cdr_pll_en;
         endcase
         if (s === e) break;
      end
   endtask

   initial begin
      rst_n = 1'b0;
      oe_pin = 1'b1;
      term_sel_high = 1'b0;
      term_sel_float = 1'b1;
      deemph_pin_low = 1'b0;
      i2c_mode = 1'b1;
      rate_ready = 1'b1;
      pix_half = 16'h00C8; // 200 ns half period
      reg_req = '0;
      n_fail = 0;
      num_checks = 0;
      idle(16);
      rst_n = 1'b1;
      idle(4);
      // defaults, an unmapped place, audio return on
      rd_chk(ADDR_FUNC_MODE, FM_RESET);
      rd_chk(ADDR_OUT_CTRL, OC_RESET);
      rd_chk(8'h0B, 8'h00);
      chk(12'(audio_return_output), 12'h001);
      chk(12'(drv.cdr_pll_en), 12'h000);
      reg_wr(ADDR_FUNC_MODE, 8'h92);
      idle(2);
      chk(12'(audio_return_output), 12'h000);
      rd_chk(ADDR_FUNC_MODE, 8'h92);
      reg_wr(ADDR_FUNC_MODE, FM_RESET);
      // 160 MHz pixel rate in automatic mode ends up retiming
      wait_sig(0, 1'b1);
      chk(12'(drv.retime_en), 12'h001);
      chk(12'(drv.cdr_pll_en), 12'h001);
      chk(12'(drv.tx_term_en), 12'h000);
      rd_chk(ADDR_FUNC_MODE, 8'h86);
      // register de-emphasis and swing, then the strap pin
      reg_wr(ADDR_OUT_CTRL, 8'h61);
      idle(3);
      chk(12'(drv.deemph), 12'(DE_2DB));
      chk(12'(drv.swing), 12'(SW_BOOST));
      chk(12'(drv.pre_emph), 12'h001);
      i2c_mode = 1'b0;
      deemph_pin_low = 1'b1;
      idle(5);
      chk(12'(drv.deemph), 12'(DE_2DB));
      chk(12'(drv.swing), 12'(SW_PIN));
      deemph_pin_low = 1'b0;
      idle(5);
      chk(12'(drv.deemph), 12'(DE_0DB));
      i2c_mode = 1'b1;
      // above 2 Gbps the floating pin turns termination on
      pix_half = 16'h007D; // 125 ns
      wait_sig(2, 1'b1);
      chk(12'(drv.tx_term_en), 12'h001);
      term_sel_float = 1'b0;
      term_sel_high = 1'b1;
      idle(5);
      chk(12'(drv.tx_term_en), 12'h000);
      term_sel_float = 1'b1; // pin never pulled low
      term_sel_high = 1'b0;
      // forced redriver in the retiming range
      reg_wr(ADDR_FUNC_MODE, 8'h80);
      idle(3);
      chk(12'(drv.cdr_pll_en), 12'h000);
      chk(12'(drv.retime_en), 12'h000);
      chk(12'(drv.deemph), 12'(DE_0DB));
      chk(12'(drv.pre_emph), 12'h000);
      idle(WIN);
      chk(12'(drv.retime_en), 12'h000);
      // forced lock at a low rate, as for jitter tests
      pix_half = 16'h0190; // 400 ns
      reg_wr(ADDR_FUNC_MODE, 8'h81);
      wait_sig(0, 1'b1);
      chk(12'(drv.retime_en), 12'h001);
      // blanked drivers across a resolution change; a large rate step
      // so that even a partly mixed window still differs by over 8
      reg_wr(ADDR_FUNC_MODE, 8'h89);
      pix_half = 16'h007D;
      wait_sig(1, 1'b0);
      chk(12'(drv.drv_en), 12'h000);
      chk(12'(drv.retime_en), 12'h000);
      wait_sig(1, 1'b1);
      idle(2);
      chk(12'(drv.retime_en), 12'h001);
      // automatic mode: too slow, back in range, too fast; a mixed
      // window may restart acquisition first, so wait for recovery off
      reg_wr(ADDR_FUNC_MODE, FM_RESET);
      pix_half = 16'h0190;
      wait_sig(3, 1'b0);
      chk(12'(drv.retime_en), 12'h000);
      chk(12'(drv.cdr_pll_en), 12'h000);
      pix_half = 16'h00C8;
      wait_sig(0, 1'b1);
      chk(12'(drv.retime_en), 12'h001);
      pix_half = 16'h004B; // 75 ns, 1365 edges per window
      wait_sig(3, 1'b0);
      chk(12'(drv.retime_en), 12'h000);
      chk(12'(drv.cdr_pll_en), 12'h000);
      // reader stalls long enough that a third window freezes, then
      // drains: the frozen word follows the two held ones
      rate_ready = 1'b0;
      idle(3 * WIN);
      chk(12'(rate_valid), 12'h001);
      chk_rng(rate_data, 12'h553, 12'h557);
      rate_ready = 1'b1;
      @(negedge clk_sys);
      chk(12'(rate_valid), 12'h001);
      chk_rng(rate_data, 12'h553, 12'h557);
      @(negedge clk_sys);
      chk(12'(rate_valid), 12'h001);
      chk_rng(rate_data, 12'h553, 12'h557);
      @(negedge clk_sys);
      chk(12'(rate_valid), 12'h000);
      // output enable low parks everything and drops writes
      oe_pin = 1'b0;
      idle(4);
      chk(12'(drv.io_hiz), 12'h001);
      chk(12'(audio_return_output), 12'h000);
      chk(12'(drv.cdr_pll_en), 12'h000);
      reg_wr(ADDR_FUNC_MODE, 8'h92);
      oe_pin = 1'b1;
      idle(5);
      rd_chk(ADDR_FUNC_MODE, FM_RESET);
      chk(12'(audio_return_output), 12'h001);
      final_report();
   end
endmodule
